// ==== inc/ifd_params.svh ====
`ifndef IFD_PARAMS_SVH
`define IFD_PARAMS_SVH

// ************************************************************
// register addresses and layout
// ************************************************************
`define IFD_FLAGS_ADDR 8'hF7
`define IFD_SCR0_ADDR 8'hFF
`define IFD_FLAGS_RESET 8'h02
`define IFD_FLAGS_WMASK 8'hD7
`define IFD_PGM_HI 7
`define IFD_PGM_LO 6
`define IFD_BANK_BIT 4
`define IFD_CARRY_BIT 2
`define IFD_ZERO_BIT 1
`define IFD_GIE_BIT 0

// ************************************************************
// opcode values
// ************************************************************
`define IFD_OP_SVC 8'h00
`define IFD_OP_NOP 8'h40
`define IFD_OP_HALT 8'h30
`define IFD_OP_PUSH_A 8'h08
`define IFD_OP_PUSH_X 8'h10
`define IFD_OP_LONG_JUMP 8'h7D
`define IFD_OP_LONG_CALL 8'h7C
`define IFD_OP_MOV_MM 8'h5F
`define IFD_OP_AND_F 8'h70
`define IFD_OP_OR_F 8'h71
`define IFD_OP_XOR_F 8'h72
`define IFD_REL_MIN 4'h8
`define IFD_SVC_VECTOR 16'h0000
`define IFD_HALT_VALUE 8'h01

`endif

// ==== inc/ifd_pkg.sv ====
package ifd_pkg;

	typedef enum logic [6:0] {
		IFD_FMT_OP = 7'b000_0001,
		IFD_FMT_REL = 7'b000_0010,
		IFD_FMT_IMM = 7'b000_0100,
		IFD_FMT_ADR = 7'b000_1000,
		IFD_FMT_LONG = 7'b001_0000,
		IFD_FMT_ADR_IMM = 7'b010_0000,
		IFD_FMT_ADR_ADR = 7'b100_0000
	} ifd_fmt_t;

	typedef struct packed {
		ifd_fmt_t fmt;
		logic [7:0] opcode;
		logic [7:0] byte1;
		logic [7:0] byte2;
		logic [1:0] length;
	} ifd_instr_t;

	typedef struct packed {
		logic [1:0] ram_page_select_mode;
		logic register_bank_select;
		logic carry;
		logic zero;
		logic global_irq_enable;
	} ifd_flags_t;

	typedef struct packed {
		logic [15:0] addr;
		logic rd;
	} ifd_fetch_req_t;

	typedef struct packed {
		logic [8:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ifd_reg_req_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ifd_ram_req_t;

endpackage

// ==== core/ifd_format_sort.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ifd_params.svh"

module ifd_format_sort
	import ifd_pkg::*;
(
	input wire logic [7:0] opcode,
	output ifd_fmt_t fmt,
	output logic [1:0] length
);

	// ************************************************************
	// opcode class to format
	// ************************************************************
	always_comb begin
		fmt = IFD_FMT_OP;
		length = 2'd1;
		if (opcode[7:4] >= `IFD_REL_MIN) begin
			fmt = IFD_FMT_REL;
			length = 2'd2;
		end else if (opcode == `IFD_OP_LONG_JUMP || opcode == `IFD_OP_LONG_CALL) begin
			fmt = IFD_FMT_LONG;
			length = 2'd3;
		end else if (opcode == `IFD_OP_MOV_MM) begin
			fmt = IFD_FMT_ADR_ADR;
			length = 2'd3;
		end else if (opcode[2:0] == 3'd7 || opcode[2:0] == 3'd3) begin
			fmt = IFD_FMT_ADR_IMM;
			length = 2'd3;
		end else if (opcode[2:0] == 3'd1 || opcode == `IFD_OP_AND_F ||
			opcode == `IFD_OP_OR_F || opcode == `IFD_OP_XOR_F) begin
			fmt = IFD_FMT_IMM;
			length = 2'd2;
		end else if (opcode[2:0] == 3'd2 || opcode[2:0] == 3'd4 ||
			opcode[2:0] == 3'd5 || opcode[2:0] == 3'd6) begin
			fmt = IFD_FMT_ADR;
			length = 2'd2;
		end
		if (opcode == `IFD_OP_SVC || opcode == `IFD_OP_NOP ||
			opcode == `IFD_OP_HALT || opcode == `IFD_OP_PUSH_A ||
			opcode == `IFD_OP_PUSH_X) begin
			fmt = IFD_FMT_OP;
			length = 2'd1;
		end
	end

endmodule
`default_nettype wire

// ==== core/ifd_rel_target.sv ====
`timescale 1ns/1ns
`default_nettype none

module ifd_rel_target (
	input wire logic [15:0] pc,
	input wire logic [11:0] offset,
	output logic [15:0] target
);

	// ************************************************************
	// sign extend and add
	// ************************************************************
	always_comb begin
		target = pc + {{4{offset[11]}}, offset};
	end

endmodule
`default_nettype wire

// ==== core/ifd_core.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ifd_params.svh"

module ifd_core
	import ifd_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	output ifd_fetch_req_t fetch_req,
	input wire logic [7:0] fetch_data,
	input wire logic fetch_ready,
	output ifd_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	output ifd_ram_req_t ram_req,
	input wire logic [7:0] ram_rdata,
	input wire logic irq,
	input wire logic [7:0] alu_flags_set,
	input wire logic alu_flags_valid,
	output ifd_instr_t instr,
	output logic instr_valid,
	output ifd_flags_t flags,
	output logic [15:0] pc,
	output logic [7:0] stack_ptr,
	output logic in_supervisory_rom,
	output logic irq_taken
);

	typedef enum logic [6:0] {
		ST_FETCH0 = 7'b000_0001,
		ST_FETCH1 = 7'b000_0010,
		ST_FETCH2 = 7'b000_0100,
		ST_EXEC = 7'b000_1000,
		ST_IRQ_PUSH = 7'b001_0000,
		ST_COPY_RD = 7'b010_0000,
		ST_COPY_WR = 7'b100_0000
	} ifd_state_t;

	// ************************************************************
	// state
	// ************************************************************
	ifd_state_t state_r;
	logic [7:0] op_r;
	logic [7:0] b1_r;
	logic [7:0] b2_r;
	logic [15:0] pc_r;
	logic [7:0] sp_r;
	logic [7:0] flags_r;
	logic [7:0] copy_r;
	logic svc_r;
	logic irq_taken_r;
	ifd_fmt_t fmt;
	logic [1:0] len;
	logic [15:0] rel_target;
	logic [7:0] flags_nxt;

	ifd_format_sort u_sort (
		.opcode(op_r),
		.fmt(fmt),
		.length(len)
	);

	ifd_rel_target u_rel (
		.pc(pc_r),
		.offset({op_r[3:0], b1_r}),
		.target(rel_target)
	);

	wire logic exec = (state_r == ST_EXEC);
	wire logic fetch_hit = fetch_req.rd && fetch_ready;
	wire logic flag_op = (op_r == `IFD_OP_AND_F) || (op_r == `IFD_OP_OR_F) ||
		(op_r == `IFD_OP_XOR_F);
	wire logic branch = (fmt == IFD_FMT_REL) || (fmt == IFD_FMT_LONG) ||
		(op_r == `IFD_OP_SVC);

	// ************************************************************
	// fetch sequencing
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= ST_FETCH0;
		end else begin
			unique case (state_r)
				ST_FETCH0: begin
					if (fetch_ready) begin
						state_r <= ST_FETCH1;
					end
				end
				ST_FETCH1: begin
					if (len == 2'd1) begin
						state_r <= ST_EXEC;
					end else if (fetch_ready) begin
						state_r <= (len == 2'd3) ? ST_FETCH2 : ST_EXEC;
					end
				end
				ST_FETCH2: begin
					if (fetch_ready) begin
						state_r <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (fmt == IFD_FMT_ADR_ADR) begin
						state_r <= ST_COPY_RD;
					end else if (irq && flags_r[`IFD_GIE_BIT]) begin
						state_r <= ST_IRQ_PUSH;
					end else begin
						state_r <= ST_FETCH0;
					end
				end
				ST_COPY_RD: begin
					state_r <= ST_COPY_WR;
				end
				ST_COPY_WR: begin
					state_r <= ST_FETCH0;
				end
				ST_IRQ_PUSH: begin
					state_r <= ST_FETCH0;
				end
			endcase
		end
	end

	// ************************************************************
	// instruction bytes
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			op_r <= 8'h00;
			b1_r <= 8'h00;
			b2_r <= 8'h00;
		end else begin
			if (state_r == ST_FETCH0 && fetch_ready) begin
				op_r <= fetch_data;
				b1_r <= 8'h00;
				b2_r <= 8'h00;
			end
			if (state_r == ST_FETCH1 && len != 2'd1 && fetch_ready) begin
				b1_r <= fetch_data;
			end
			if (state_r == ST_FETCH2 && fetch_ready) begin
				b2_r <= fetch_data;
			end
		end
	end

	// ************************************************************
	// program counter and supervisory entry
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			pc_r <= 16'h0000;
			svc_r <= 1'b0;
		end else if (exec) begin
			if (fmt == IFD_FMT_REL) begin
				pc_r <= rel_target;
			end else if (fmt == IFD_FMT_LONG) begin
				pc_r <= {b1_r, b2_r};
			end else if (op_r == `IFD_OP_SVC) begin
				pc_r <= `IFD_SVC_VECTOR;
				svc_r <= 1'b1;
			end else begin
				pc_r <= pc_r + {14'h0000, len};
			end
		end
	end

	// ************************************************************
	// fetch port
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			fetch_req <= '0;
		end else begin
			// drop the strobe on the answer so one byte is asked once
			fetch_req.rd <= !fetch_ready && ((state_r == ST_FETCH0) ||
				(state_r == ST_FETCH1 && len != 2'd1) ||
				state_r == ST_FETCH2);
			unique case (state_r)
				ST_FETCH1: fetch_req.addr <= pc_r + 16'h0001;
				ST_FETCH2: fetch_req.addr <= pc_r + 16'h0002;
				default: fetch_req.addr <= pc_r;
			endcase
		end
	end

	// ************************************************************
	// stack pointer
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			sp_r <= 8'h00;
		end else if ((exec && (op_r == `IFD_OP_PUSH_A ||
			op_r == `IFD_OP_PUSH_X)) || state_r == ST_IRQ_PUSH) begin
			sp_r <= sp_r + 8'h01;
		end
	end

	// ************************************************************
	// RAM port
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			ram_req <= '0;
			copy_r <= 8'h00;
		end else begin
			ram_req <= '0;
			if (exec && (op_r == `IFD_OP_PUSH_A || op_r == `IFD_OP_PUSH_X)) begin
				ram_req.addr <= sp_r;
				ram_req.wr <= 1'b1;
			end else if (exec && fmt == IFD_FMT_ADR_ADR) begin
				ram_req.addr <= b2_r;
				ram_req.rd <= 1'b1;
			end else if (state_r == ST_COPY_RD) begin
				copy_r <= ram_rdata;
			end else if (state_r == ST_COPY_WR) begin
				ram_req.addr <= b1_r;
				ram_req.wdata <= copy_r;
				ram_req.wr <= 1'b1;
			end else if (state_r == ST_IRQ_PUSH) begin
				ram_req.addr <= sp_r;
				ram_req.wdata <= flags_r;
				ram_req.wr <= 1'b1;
			end
		end
	end

	// ************************************************************
	// register port
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_req <= '0;
		end else begin
			reg_req <= '0;
			if (exec && op_r == `IFD_OP_HALT) begin
				reg_req.addr <= {1'b0, `IFD_SCR0_ADDR};
				reg_req.wdata <= `IFD_HALT_VALUE;
				reg_req.wr <= 1'b1;
			end else if (exec && fmt == IFD_FMT_ADR) begin
				reg_req.addr <= {flags_r[`IFD_BANK_BIT], b1_r};
				reg_req.rd <= 1'b1;
			end
		end
	end

	// ************************************************************
	// flag register
	// ************************************************************
	always_comb begin
		flags_nxt = flags_r;
		if (exec && flag_op) begin
			unique case (op_r)
				`IFD_OP_AND_F: flags_nxt = flags_r & b1_r;
				`IFD_OP_OR_F: flags_nxt = flags_r | b1_r;
				default: flags_nxt = flags_r ^ b1_r;
			endcase
		end else if (alu_flags_valid) begin
			flags_nxt[`IFD_CARRY_BIT] = alu_flags_set[`IFD_CARRY_BIT];
			flags_nxt[`IFD_ZERO_BIT] = alu_flags_set[`IFD_ZERO_BIT];
		end
		if (exec && op_r == `IFD_OP_SVC) begin
			flags_nxt[`IFD_PGM_HI:`IFD_PGM_LO] = 2'b00;
		end
		flags_nxt = flags_nxt & `IFD_FLAGS_WMASK;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			flags_r <= `IFD_FLAGS_RESET;
			irq_taken_r <= 1'b0;
		end else begin
			irq_taken_r <= 1'b0;
			if (state_r == ST_IRQ_PUSH) begin
				flags_r <= flags_nxt & ~(8'h01 << `IFD_GIE_BIT);
				irq_taken_r <= 1'b1;
			end else begin
				flags_r <= flags_nxt;
			end
		end
	end

	// ************************************************************
	// decoded outputs
	// ************************************************************
	always_ff @(posedge clock) begin
		if (srst) begin
			instr <= '{fmt: IFD_FMT_OP, opcode: 8'h00, byte1: 8'h00,
				byte2: 8'h00, length: 2'd1};
			instr_valid <= 1'b0;
		end else begin
			// valid in the same cycle as the decoded word
			instr_valid <= exec;
			if (exec) begin
				instr <= '{fmt: fmt, opcode: op_r, byte1: b1_r,
					byte2: b2_r, length: len};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			flags <= '0;
			pc <= 16'h0000;
			stack_ptr <= 8'h00;
			in_supervisory_rom <= 1'b0;
			irq_taken <= 1'b0;
		end else begin
			flags <= {flags_r[7:6], flags_r[4], flags_r[2:0]};
			pc <= pc_r;
			stack_ptr <= sp_r;
			in_supervisory_rom <= svc_r;
			irq_taken <= irq_taken_r;
		end
	end

	wire logic unused_ok = ^{reg_rdata, branch, alu_flags_set[7:3],
		alu_flags_set[0]};

endmodule
`default_nettype wire

// ==== verification/ifd_core_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ifd_params.svh"

module ifd_core_props
	import ifd_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire ifd_reg_req_t reg_req,
	input wire ifd_instr_t instr,
	input wire logic instr_valid,
	input wire ifd_flags_t flags,
	input wire logic [7:0] stack_ptr,
	input wire logic in_supervisory_rom,
	input wire logic irq_taken
);
	logic [3:0] gie_low_r;

	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	// cycles since interrupt enable was last set
	always_ff @(posedge clock) begin
		if (srst || flags.global_irq_enable)
			gie_low_r <= 4'h0;
		else if (gie_low_r != 4'hF)
			gie_low_r <= gie_low_r + 4'h1;
	end

	// ****
	// properties
	// ****
	property p_len;
		instr_valid |-> instr.length == (instr.fmt == IFD_FMT_OP ? 2'd1 :
			instr.fmt inside {IFD_FMT_REL, IFD_FMT_IMM, IFD_FMT_ADR} ?
			2'd2 : 2'd3);
	endproperty
	a_len: assert property (p_len)
		else $error("length does not fit format");
	property p_rel;
		instr_valid && instr.opcode[7:4] >= `IFD_REL_MIN |->
			instr.fmt == IFD_FMT_REL;
	endproperty
	a_rel: assert property (p_rel)
		else $error("short branch not relative format");
	property p_long;
		instr_valid && instr.opcode == `IFD_OP_LONG_JUMP |->
			instr.fmt == IFD_FMT_LONG;
	endproperty
	a_long: assert property (p_long)
		else $error("long jump not long format");
	property p_svc;
		instr_valid && instr.opcode == `IFD_OP_SVC |->
			instr.fmt == IFD_FMT_OP ##[0:4] in_supervisory_rom;
	endproperty
	a_svc: assert property (p_svc)
		else $error("supervisor call not entering rom code");
	property p_stop;
		reg_req.wr |-> reg_req.addr == {1'b0, `IFD_SCR0_ADDR} &&
			reg_req.wdata == `IFD_HALT_VALUE;
	endproperty
	a_stop: assert property (p_stop)
		else $error("register write other than stop");
	property p_pulse;
		reg_req.wr |=> !reg_req.wr;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("register write longer than one cycle");
	property p_sp;
		$changed(stack_ptr) |-> stack_ptr == $past(stack_ptr) + 8'h01;
	endproperty
	a_sp: assert property (p_sp)
		else $error("stack pointer step not one");
	property p_gate;
		irq_taken |-> gie_low_r < 4'h8;
	endproperty
	a_gate: assert property (p_gate)
		else $error("interrupt taken while disabled");
	property p_gie_clr;
		irq_taken |-> ##[0:8] !flags.global_irq_enable;
	endproperty
	a_gie_clr: assert property (p_gie_clr)
		else $error("interrupt enable not cleared");

	c_rel: cover property (instr_valid && instr.fmt == IFD_FMT_REL);
	c_copy: cover property (instr_valid && instr.fmt == IFD_FMT_ADR_ADR);
	c_irq: cover property (irq_taken);
	c_stop: cover property (reg_req.wr);
endmodule

bind ifd_core ifd_core_props u_props (.*);

`default_nettype wire

// ==== verification/ifd_prog_mem.sv ====
`timescale 1ns/1ns
`default_nettype none

module ifd_prog_mem
	import ifd_pkg::*;
(
	input wire logic clock,
	input wire ifd_fetch_req_t fetch_req,
	output logic [7:0] fetch_data,
	output logic fetch_ready,
	input wire ifd_ram_req_t ram_req,
	output logic [7:0] ram_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] ram [0:255];
	logic [1:0] wait_r = 2'd0;
	logic rd_r = 1'b0;
	logic [7:0] addr_r = 8'h00;

	initial begin
		fetch_data = 8'h00;
		fetch_ready = 1'b0;
		for (int i = 0; i < 256; i++) ram[i] = 8'(i) ^ 8'hA5;
	end

	// ****
	// program port: byte after 0..3 idle cycles, garbage otherwise
	// ****
	always @(posedge clock) begin
		if (fetch_ready) begin
			fetch_ready <= 1'b0;
			fetch_data <= ~fetch_data;
		end else if (fetch_req.rd && wait_r != 2'd0) begin
			wait_r <= wait_r - 2'd1;
			fetch_data <= ~fetch_data;
		end else if (fetch_req.rd) begin
			fetch_ready <= 1'b1;
			fetch_data <= mem[fetch_req.addr];
			wait_r <= 2'($urandom_range(0, 3));
		end else
			fetch_data <= ~fetch_data;
	end

	// data valid in read cycle and the next one only
	always @(posedge clock) begin
		rd_r <= ram_req.rd;
		addr_r <= ram_req.addr;
		if (ram_req.wr)
			ram[ram_req.addr] <= ram_req.wdata;
	end
	assign ram_rdata = ram_req.rd ? ram[ram_req.addr] :
		rd_r ? ram[addr_r] : ~addr_r;
endmodule

`default_nettype wire

// ==== verification/ifd_core_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ifd_params.svh"

`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((e) !== (g)) begin \
		errors++; \
		$display("mismatch %s exp %h got %h", nm, e, g); \
	end \
end

module ifd_core_tb
	import ifd_pkg::*;
;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic irq = 1'b0;
	logic [7:0] alu_flags_set = 8'h00;
	logic alu_flags_valid = 1'b0;
	ifd_fetch_req_t fetch_req;
	ifd_reg_req_t reg_req;
	ifd_ram_req_t ram_req;
	ifd_instr_t instr;
	ifd_flags_t flags;
	logic [7:0] fetch_data;
	logic [7:0] ram_rdata;
	logic [7:0] stack_ptr;
	logic fetch_ready;
	logic instr_valid;
	logic in_supervisory_rom;
	logic irq_taken;
	logic [15:0] pc;
	logic [15:0] pc_e;
	logic [7:0] fl_e;
	logic [7:0] sp_e;
	logic fl_ok;
	int errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_irq = 0;
	int n_wr = 0;

	always #25 clock = ~clock;

	ifd_core u_dut (.*, .reg_rdata(8'h00));
	ifd_prog_mem u_mem (.*);

	always @(posedge clock) begin
		cyc++;
		if (irq_taken === 1'b1)
			n_irq++;
		if (reg_req.wr === 1'b1)
			n_wr++;
		if (cyc == 40000) begin
			errors++;
			summarize();
		end
	end

	// ****
	// expectation helpers
	// ****
	function automatic logic [1:0] len_of(input logic [7:0] op);
		if (op[7:4] >= `IFD_REL_MIN || op inside {8'h70, 8'h71, 8'h72})
			return 2'd2;
		if (op inside {`IFD_OP_LONG_JUMP, `IFD_OP_MOV_MM})
			return 2'd3;
		return 2'd1;
	endfunction

	function automatic ifd_fmt_t fmt_of(input logic [7:0] op);
		if (op[7:4] >= `IFD_REL_MIN)
			return IFD_FMT_REL;
		if (op == `IFD_OP_LONG_JUMP)
			return IFD_FMT_LONG;
		if (op == `IFD_OP_MOV_MM)
			return IFD_FMT_ADR_ADR;
		return len_of(op) == 2'd2 ? IFD_FMT_IMM : IFD_FMT_OP;
	endfunction

	function automatic logic [7:0] fbyte();
		return {flags[5:4], 1'b0, flags[3], 1'b0, flags[2:0]};
	endfunction

	task automatic put(inout logic [15:0] a, input logic [7:0] op,
		input logic [7:0] b1 = 8'h00, input logic [7:0] b2 = 8'h00);
		u_mem.mem[a] = op;
		if (len_of(op) > 2'd1)
			u_mem.mem[a + 16'h0001] = b1;
		if (len_of(op) > 2'd2)
			u_mem.mem[a + 16'h0002] = b2;
		a = a + 16'(len_of(op));
	endtask

	task automatic restart();
		@(posedge clock);
		srst <= 1'b1;
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		pc_e = 16'h0000;
		fl_e = `IFD_FLAGS_RESET;
		sp_e = 8'h00;
		fl_ok = 1'b1;
	endtask

	task automatic step(output logic h);
		logic [7:0] op;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [1:0] n;
		int k;
		op = u_mem.mem[pc_e];
		b1 = u_mem.mem[pc_e + 16'h0001];
		b2 = u_mem.mem[pc_e + 16'h0002];
		n = len_of(op);
		k = 0;
		do begin
			@(posedge clock);
			#1;
			k++;
		end while (instr_valid !== 1'b1 && k < 60);
		`CHK("valid", 1'b1, instr_valid)
		`CHK("pc", pc_e, pc)
		`CHK("opcode", op, instr.opcode)
		`CHK("fmt", fmt_of(op), instr.fmt)
		`CHK("length", n, instr.length)
		if (n > 2'd1) `CHK("byte1", b1, instr.byte1)
		if (n > 2'd2) `CHK("byte2", b2, instr.byte2)
		if (fl_ok && !(op inside {8'h70, 8'h71, 8'h72}))
			`CHK("flags", fl_e, fbyte())
		if (!(op inside {`IFD_OP_PUSH_A, `IFD_OP_PUSH_X}))
			`CHK("stack", sp_e, stack_ptr)
		case (op)
			`IFD_OP_AND_F: fl_e = fl_e & b1;
			`IFD_OP_OR_F: fl_e = fl_e | b1;
			`IFD_OP_XOR_F: fl_e = fl_e ^ b1;
			`IFD_OP_PUSH_A, `IFD_OP_PUSH_X: sp_e = sp_e + 8'h01;
			`IFD_OP_SVC: fl_ok = 1'b0;
			default: ;
		endcase
		h = (op == `IFD_OP_HALT);
		if (op[7:4] >= `IFD_REL_MIN)
			pc_e = pc_e + {{4{op[3]}}, op[3:0], b1};
		else if (op == `IFD_OP_LONG_JUMP)
			pc_e = {b1, b2};
		else if (op == `IFD_OP_SVC)
			pc_e = `IFD_SVC_VECTOR;
		else
			pc_e = pc_e + 16'(n);
	endtask

	task automatic run(input int n);
		logic h;
		h = 1'b0;
		for (int i = 0; i < n && !h; i++) step(h);
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****
	// scenarios
	// ****
	initial begin
		logic [15:0] a;
		logic [15:0] t;
		logic [7:0] r;
		void'($urandom(95));
		@(posedge clock);
		for (int i = 0; i < 65536; i++) u_mem.mem[i] = `IFD_OP_NOP;
		// flag logic, pushes, copy, branch range ends, stop
		a = 16'h0000;
		put(a, `IFD_OP_OR_F, `IFD_FLAGS_WMASK);
		put(a, `IFD_OP_XOR_F, 8'($urandom) & `IFD_FLAGS_WMASK);
		put(a, `IFD_OP_AND_F, 8'($urandom) & `IFD_FLAGS_WMASK);
		put(a, `IFD_OP_PUSH_A);
		put(a, `IFD_OP_PUSH_X);
		put(a, `IFD_OP_MOV_MM, 8'h80, 8'h81);
		put(a, `IFD_OP_LONG_JUMP, 8'h40, 8'h00);
		a = 16'h4000;
		put(a, 8'h87, 8'hFF);
		a = 16'h47FF;
		put(a, 8'h88, 8'h00);
		a = 16'h3FFF;
		put(a, `IFD_OP_HALT);
		restart();
		repeat (3) @(posedge clock);
		#1;
		`CHK("reset flags", `IFD_FLAGS_RESET, fbyte())
		run(20);
		repeat (4) @(posedge clock);
		`CHK("stop writes", 1, n_wr)
		`CHK("copy", 8'h81 ^ 8'hA5, u_mem.ram[8'h80])
		// random walk, always forward, ending in a supervisor call
		a = 16'h0000;
		put(a, `IFD_OP_LONG_JUMP, 8'h80, 8'h00);
		a = 16'h8000;
		repeat (40) begin
			r = 8'($urandom);
			case ($urandom_range(0, 6))
				0: put(a, `IFD_OP_NOP);
				1: put(a, `IFD_OP_PUSH_A);
				2: put(a, `IFD_OP_PUSH_X);
				3: put(a, 8'h70 + 8'($urandom_range(0, 2)),
					r & `IFD_FLAGS_WMASK);
				4: put(a, `IFD_OP_MOV_MM, r, 8'($urandom));
				5: begin
					t = a + {8'h01, r};
					put(a, 8'h81, r);
					a = t;
				end
				default: begin
					t = a + 16'h0400 + 16'($urandom_range(0, 1023));
					put(a, `IFD_OP_LONG_JUMP, t[15:8], t[7:0]);
					a = t;
				end
			endcase
		end
		put(a, `IFD_OP_SVC);
		restart();
		run(70);
		`CHK("rom entry", 1'b1, in_supervisory_rom)
		// interrupt refused while disabled, then taken once
		a = 16'h0000;
		put(a, `IFD_OP_AND_F, 8'h00);
		put(a, 8'h80, 8'h00);
		restart();
		run(2);
		irq <= 1'b1;
		repeat (30) @(posedge clock);
		`CHK("irq masked", 0, n_irq)
		a = 16'h0004;
		put(a, `IFD_OP_OR_F, 8'h01);
		u_mem.mem[16'h0006] = 8'h80;
		u_mem.mem[16'h0007] = 8'h00;
		u_mem.mem[16'h0003] = 8'h02;
		for (int i = 0; i < 100 && n_irq == 0; i++) @(posedge clock);
		irq <= 1'b0;
		repeat (20) @(posedge clock);
		`CHK("irq taken", 1, n_irq)
		// result flags from the arithmetic side while looping
		alu_flags_set <= 8'($urandom);
		alu_flags_valid <= 1'b1;
		@(posedge clock);
		alu_flags_valid <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		`CHK("alu carry", alu_flags_set[2], flags.carry)
		`CHK("alu zero", alu_flags_set[1], flags.zero)
		summarize();
	end
endmodule

`default_nettype wire
